// [src/psc_defines.svh]
// offsets, field positions, reset values and timing figures of the control bank
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
`define PSC_OFS_PAGE        8'h00
`define PSC_OFS_SRST        8'h01
`define PSC_OFS_SLEEP       8'h02
`define PSC_OFS_SHDN        8'h05
`define PSC_RST_PAGE        8'h00
`define PSC_RST_SLEEP       8'h00
`define PSC_RST_SHDN        8'h05
`define PSC_SLEEP_WMASK     8'hFD
`define PSC_SHDN_WMASK      8'h3F
`define PSC_BIT_SRST        0
`define PSC_BIT_AWAKE       0
`define PSC_BIT_BCAST       2
`define PSC_FLD_REFQ        4:3
`define PSC_BIT_RAIL        7
`define PSC_FLD_HOLD        1:0
`define PSC_FLD_POLICY      3:2
`define PSC_FLD_INCAP       5:4
`define PSC_BCAST_ADDR      7'h4C
`define PSC_CLK_MHZ         50
`define PSC_TICK_US         50
`define PSC_REFQ0_US        3500
`define PSC_REFQ1_US        10000
`define PSC_REFQ2_US        50000
`define PSC_REFQ3_US        100000
`define PSC_INCAP0_US       2500
`define PSC_INCAP1_US       12500
`define PSC_INCAP2_US       25000
`define PSC_INCAP3_US       50000
`define PSC_HOLD0_US        30000
`define PSC_HOLD1_US        25000
`define PSC_HOLD2_US        10000
`define PSC_HOLD3_US        5000
`define PSC_POL_IMMED       2'h0
`define PSC_POL_TIMEOUT     2'h1
`define PSC_POL_CLEAN       2'h2
`endif

// [src/psc_pkg.sv]
// types shared by the control bank
package psc_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psc_req_t;
    typedef enum logic [1:0] {CORE_ON, CORE_HOLD, CORE_OFF} psc_core_t;
endpackage : psc_pkg

// [src/psc_ctrl.sv]
// page, soft reset, sleep, supply and shutdown control register bank
//
// What this block does
// - eight-bit page select at offset zero
// - soft reset restores page, sleep and shutdown register defaults
// - soft reset bit clears itself, reads zero
// - bit 7 picks external or on-chip analog rail
// - reference precharge code picks 3.5-100 ms
// - broadcast bit fixes bus address, else straps
// - awake enable zero keeps device asleep
// - input precharge code picks 2.5-50 ms
// - powerdown policy governs core regulator after shutdown
// - hold time code gives 30/25/10/5 ms
// - shutdown configuration resets to 5h
`timescale 1ns/1ns
`default_nettype none
`include "psc_defines.svh"
module psc_ctrl #(
    parameter int       TICK_CYCLES = `PSC_TICK_US * `PSC_CLK_MHZ,
    parameter bit [4:0] STRAP_BASE  = 5'h00
) (
    input  wire logic             CLK,
    input  wire logic             RST_N,
    input  wire psc_pkg::psc_req_t REG_REQ,
    output logic [7:0]            REG_RDATA,
    output logic                  REG_RVALID,
    output logic [7:0]            PAGE,
    input  wire logic [1:0]       ADDR_STRAP,
    output logic [6:0]            BUS_ADDR,
    output logic                  AWAKE,
    output logic                  ANALOG_REG_EN,
    output logic                  REF_PRECHARGE,
    output logic                  INCAP_PRECHARGE,
    input  wire logic             SHUTDOWN_PIN_N,
    input  wire logic             CLEAN_DONE,
    output logic                  CORE_REG_EN
);
    import psc_pkg::*;

    // tick counts of each selectable duration
    function automatic logic [11:0] ref_ticks(input logic [1:0] code);
        unique case (code)
            2'h0: ref_ticks = 12'(`PSC_REFQ0_US / `PSC_TICK_US);
            2'h1: ref_ticks = 12'(`PSC_REFQ1_US / `PSC_TICK_US);
            2'h2: ref_ticks = 12'(`PSC_REFQ2_US / `PSC_TICK_US);
            2'h3: ref_ticks = 12'(`PSC_REFQ3_US / `PSC_TICK_US);
        endcase
    endfunction : ref_ticks

    function automatic logic [11:0] incap_ticks(input logic [1:0] code);
        unique case (code)
            2'h0: incap_ticks = 12'(`PSC_INCAP0_US / `PSC_TICK_US);
            2'h1: incap_ticks = 12'(`PSC_INCAP1_US / `PSC_TICK_US);
            2'h2: incap_ticks = 12'(`PSC_INCAP2_US / `PSC_TICK_US);
            2'h3: incap_ticks = 12'(`PSC_INCAP3_US / `PSC_TICK_US);
        endcase
    endfunction : incap_ticks

    function automatic logic [11:0] hold_ticks(input logic [1:0] code);
        unique case (code)
            2'h0: hold_ticks = 12'(`PSC_HOLD0_US / `PSC_TICK_US);
            2'h1: hold_ticks = 12'(`PSC_HOLD1_US / `PSC_TICK_US);
            2'h2: hold_ticks = 12'(`PSC_HOLD2_US / `PSC_TICK_US);
            2'h3: hold_ticks = 12'(`PSC_HOLD3_US / `PSC_TICK_US);
        endcase
    endfunction : hold_ticks

    logic [7:0]  page_q;
    logic [7:0]  sleep_q;
    logic [7:0]  shdn_q;
    logic        srst_q;
    logic [7:0]  rdata_q;
    logic        rvalid_q;
    logic [1:0]  strap_q;
    logic        strap_done_q;
    logic [6:0]  bus_addr_q;
    logic        awake_q;
    logic        rail_sel_q;
    logic [15:0] psc_cnt_q;
    logic        tick_q;
    logic [11:0] pre_cnt_q [2];
    logic        pre_act_q [2];
    logic [11:0] hold_cnt_q;
    psc_core_t   core_q;
    logic        core_en_q;

    // access decode; page 0 holds the bank, page select is on every page
    wire         hit_page  = REG_REQ.addr == `PSC_OFS_PAGE;
    wire         on_page0  = page_q == 8'h00;
    wire         hit_srst  = on_page0 && REG_REQ.addr == `PSC_OFS_SRST;
    wire         hit_sleep = on_page0 && REG_REQ.addr == `PSC_OFS_SLEEP;
    wire         hit_shdn  = on_page0 && REG_REQ.addr == `PSC_OFS_SHDN;
    wire         srst_d    = REG_REQ.wr && hit_srst && REG_REQ.wdata[`PSC_BIT_SRST];

    // named fields of the stored registers
    wire         awake_enable             = sleep_q[`PSC_BIT_AWAKE];
    wire         analog_rail_source_sel   = sleep_q[`PSC_BIT_RAIL];
    wire         broadcast_address_enable = sleep_q[`PSC_BIT_BCAST];
    wire [1:0]   ref_cap_precharge_time   = sleep_q[`PSC_FLD_REFQ];
    wire [1:0]   input_cap_precharge_time = shdn_q[`PSC_FLD_INCAP];
    wire [1:0]   powerdown_policy         = shdn_q[`PSC_FLD_POLICY];
    wire [1:0]   core_supply_hold_time    = shdn_q[`PSC_FLD_HOLD];

    // wake-up edge and the tick counts loaded into the precharge timers
    wire         wake_d    = awake_enable;
    wire         wake_rise = wake_d && !awake_q;
    wire [11:0]  pre_load [2];
    assign pre_load[0] = ref_ticks(ref_cap_precharge_time);
    assign pre_load[1] = incap_ticks(input_cap_precharge_time);

    // policy decode; code 3 falls to immediate power-off
    wire [1:0]   policy      = powerdown_policy;
    wire         policy_keep = policy == `PSC_POL_TIMEOUT || policy == `PSC_POL_CLEAN;
    wire         hold_over   = policy == `PSC_POL_TIMEOUT && hold_cnt_q == 12'h000;
    wire [11:0]  hold_load   = hold_ticks(core_supply_hold_time);

    // read mux; reserved bits and unmapped offsets read zero
    wire [7:0]   rd_mux = hit_page  ? page_q :
                          hit_srst  ? {7'h00, srst_q} :
                          hit_sleep ? sleep_q :
                          hit_shdn  ? shdn_q : 8'h00;

    // write strobes; a pending soft reset swallows them
    wire         wr_page  = REG_REQ.wr && hit_page;
    wire         wr_sleep = REG_REQ.wr && hit_sleep;
    wire         wr_shdn  = REG_REQ.wr && hit_shdn;

    // page select, restored by soft reset
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            page_q <= `PSC_RST_PAGE;
        else if (srst_q)
            page_q <= `PSC_RST_PAGE;
        else if (wr_page)
            page_q <= REG_REQ.wdata;
    end

    // sleep register, read-only bit masked off
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            sleep_q <= `PSC_RST_SLEEP;
        else if (srst_q)
            sleep_q <= `PSC_RST_SLEEP;
        else if (wr_sleep)
            sleep_q <= REG_REQ.wdata & `PSC_SLEEP_WMASK;
    end

    // shutdown register, back to 5h on either reset
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            shdn_q <= `PSC_RST_SHDN;
        else if (srst_q)
            shdn_q <= `PSC_RST_SHDN;
        else if (wr_shdn)
            shdn_q <= REG_REQ.wdata & `PSC_SHDN_WMASK;
    end

    // trigger lives one cycle, then clears itself
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            srst_q <= 1'b0;
        else
            srst_q <= srst_d && !srst_q;
    end

    // read answer one cycle after the strobe
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= REG_REQ.rd ? rd_mux : 8'h00;
            rvalid_q <= REG_REQ.rd;
        end
    end

    // straps caught once after reset release
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_q      <= 2'b00;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_q      <= ADDR_STRAP;
            strap_done_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            bus_addr_q <= 7'h00;
        else if (broadcast_address_enable)
            bus_addr_q <= `PSC_BCAST_ADDR;
        else
            bus_addr_q <= {STRAP_BASE, strap_q};
    end

    // sleep state; zero keeps the device asleep
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            awake_q <= 1'b0;
        else
            awake_q <= wake_d;
    end

    // analog rail source: external at zero, on-chip at one
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            rail_sel_q <= 1'b0;
        else
            rail_sel_q <= analog_rail_source_sel;
    end

    // last count of the tick divider
    wire         tick_wrap = psc_cnt_q == 16'(TICK_CYCLES - 1);

    // time base: one tick per TICK_CYCLES clocks
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            psc_cnt_q <= 16'h0000;
            tick_q    <= 1'b0;
        end else begin
            tick_q    <= tick_wrap;
            psc_cnt_q <= tick_wrap ? 16'h0000 : psc_cnt_q + 16'h0001;
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_pre
        // the tick that ends a running charge
        wire pre_last = tick_q && pre_cnt_q[i] == 12'h001;
        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                pre_cnt_q[i] <= 12'h000;
                pre_act_q[i] <= 1'b0;
            end else if (srst_q || !wake_d) begin
                pre_cnt_q[i] <= 12'h000;
                pre_act_q[i] <= 1'b0;
            end else if (wake_rise) begin
                pre_cnt_q[i] <= pre_load[i];
                pre_act_q[i] <= 1'b1;
            end else if (tick_q && pre_cnt_q[i] != 12'h000) begin
                pre_cnt_q[i] <= pre_cnt_q[i] - 12'h001;
                pre_act_q[i] <= !pre_last;
            end
        end
    end

    // core regulator keep-alive after shutdown pin asserts
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            core_q     <= CORE_ON;
            hold_cnt_q <= 12'h000;
            core_en_q  <= 1'b1;
        end else begin
            unique case (core_q)
                CORE_ON: begin
                    core_en_q <= 1'b1;
                    if (!SHUTDOWN_PIN_N) begin
                        hold_cnt_q <= hold_load;
                        if (policy_keep) begin
                            core_q <= CORE_HOLD;
                        end else begin
                            core_q    <= CORE_OFF;
                            core_en_q <= 1'b0;
                        end
                    end
                end
                // keep the core alive until release, clean end or hold expiry
                CORE_HOLD: begin
                    if (tick_q && hold_cnt_q != 12'h000)
                        hold_cnt_q <= hold_cnt_q - 12'h001;
                    if (SHUTDOWN_PIN_N) begin
                        core_q <= CORE_ON;
                    end else if (CLEAN_DONE || hold_over) begin
                        core_q    <= CORE_OFF;
                        core_en_q <= 1'b0;
                    end
                end
                // off until the shutdown pin is released
                CORE_OFF: begin
                    if (SHUTDOWN_PIN_N) begin
                        core_q    <= CORE_ON;
                        core_en_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // outputs straight from flops
    assign REG_RDATA       = rdata_q;
    assign REG_RVALID      = rvalid_q;
    assign PAGE            = page_q;
    assign BUS_ADDR        = bus_addr_q;
    assign AWAKE           = awake_q;
    assign ANALOG_REG_EN   = rail_sel_q;
    assign REF_PRECHARGE   = pre_act_q[0];
    assign INCAP_PRECHARGE = pre_act_q[1];
    assign CORE_REG_EN     = core_en_q;
endmodule : psc_ctrl
`default_nettype wire

// [dv/psc_ctrl_asserts.sv]
// assertion checker for the control bank ports
`timescale 1ns/1ns
`default_nettype none
module psc_ctrl_asserts (
    input wire logic              CLK,
    input wire logic              RST_N,
    input wire psc_pkg::psc_req_t REG_REQ,
    input wire logic [7:0]        REG_RDATA,
    input wire logic [7:0]        PAGE,
    input wire logic [6:0]        BUS_ADDR,
    input wire logic              AWAKE,
    input wire logic              ANALOG_REG_EN,
    input wire logic              SHUTDOWN_PIN_N,
    input wire logic              CLEAN_DONE,
    input wire logic              CORE_REG_EN
);
    import psc_pkg::*;
    logic       wr0;
    logic       srst_q;
    logic [1:0] pol_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // page-0 write that a pending soft reset does not swallow
    assign wr0 = REG_REQ.wr && PAGE == 8'h00 && !srst_q;
    // soft reset pending flag and powerdown policy shadow
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            srst_q <= 1'b0;
            pol_q  <= 2'h1;
        end else begin
            srst_q <= wr0 && REG_REQ.addr == 8'h01 && REG_REQ.wdata[0];
            pol_q  <= srst_q ? 2'h1 : (wr0 && REG_REQ.addr == 8'h05) ? REG_REQ.wdata[3:2] : pol_q;
        end
    end
    sequence s_sleep;
        wr0 && REG_REQ.addr == 8'h02;
    endsequence
    sequence s_cleared;
        PAGE == 8'h00 ##1 !AWAKE && !ANALOG_REG_EN;
    endsequence
    a_page_write: assert property (
        wr0 && REG_REQ.addr == 8'h00 |=> PAGE == $past(REG_REQ.wdata)) else $error("page lost");
    a_srst_default: assert property (
        srst_q |=> s_cleared) else $error("soft reset left state");
    a_srst_clear: assert property (
        REG_REQ.rd && REG_REQ.addr == 8'h01 && !srst_q |=> REG_RDATA == 8'h00) else $error("srst");
    a_analog_rail_follow: assert property (
        s_sleep |=> ##1 ANALOG_REG_EN == $past(REG_REQ.wdata[7], 2)) else $error("rail select");
    a_bcast_addr: assert property (
        s_sleep ##0 REG_REQ.wdata[2] |=> ##1 BUS_ADDR == 7'h4C) else $error("broadcast address");
    a_awake_follow: assert property (
        s_sleep |=> ##1 AWAKE == $past(REG_REQ.wdata[0], 2)) else $error("awake state");
    a_core_immed: assert property (
        !SHUTDOWN_PIN_N && pol_q[1] == pol_q[0] |=> !CORE_REG_EN) else $error("core kept on");
    a_hold_min: assert property (
        $fell(SHUTDOWN_PIN_N) && pol_q == 2'h1 && !CLEAN_DONE |=> CORE_REG_EN [*8])
        else $error("core hold too short");
endmodule : psc_ctrl_asserts
bind psc_ctrl psc_ctrl_asserts u_chk (
    .CLK(CLK), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .PAGE(PAGE),
    .BUS_ADDR(BUS_ADDR), .AWAKE(AWAKE), .ANALOG_REG_EN(ANALOG_REG_EN),
    .SHUTDOWN_PIN_N(SHUTDOWN_PIN_N), .CLEAN_DONE(CLEAN_DONE), .CORE_REG_EN(CORE_REG_EN));
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the control bank
`timescale 1ns/1ns
`default_nettype none
module tb;
    import psc_pkg::*;
    localparam int T = 4;
    logic       clk;
    logic       rst_n = 1'b0;
    logic       pin_n = 1'b1;
    logic       clean = 1'b0;
    psc_req_t   req   = '0;
    logic [7:0] rdata;
    logic [6:0] baddr;
    logic       rvalid, awake, rail, refp, incp, core;
    logic [7:0] page;
    logic [1:0] strap = 2'h2;
    int         failures = 0;
    int         n_tests  = 0;
    int         nr, ni;
    int         rt[4] = '{70, 200, 1000, 2000};
    int         it[4] = '{50, 250, 500, 1000};
    int         ht[4] = '{600, 500, 200, 100};
    psc_ctrl #(.TICK_CYCLES(T), .STRAP_BASE(5'h00)) dut (
        .CLK(clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .PAGE(page), .ADDR_STRAP(strap), .BUS_ADDR(baddr), .AWAKE(awake), .ANALOG_REG_EN(rail),
        .REF_PRECHARGE(refp), .INCAP_PRECHARGE(incp), .SHUTDOWN_PIN_N(pin_n),
        .CLEAN_DONE(clean), .CORE_REG_EN(core));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // watchdog against a hang
    initial begin
        #1000000;
        failures++;
        end_sim();
    end
    // tick-granular duration with one tick of slack
    function automatic logic near(input int n, input int ticks);
        return n >= ticks * T - T - 2 && n <= ticks * T + T + 2;
    endfunction : near
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = {1'b1, 1'b0, a, d};
        cyc(1);
        req = '0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        req = {1'b0, 1'b1, a, 8'h00};
        cyc(1);
        req = '0;
        chk({rvalid, rdata}, {1'b1, e});
        cyc(1);
    endtask : rd
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    // main sequence of register tests
    initial begin
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h00);
        rd(8'h05, 8'h05);
        chk({core, awake, baddr}, 16'h0102);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'hFF);
        chk(page, 8'hFF);
        rd(8'h05, 8'h00);
        wr(8'h00, 8'h00);
        wr(8'h01, 8'hFE);
        rd(8'h01, 8'h00);
        $display("test reset and page done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h05, {2'b11, k[1:0], 4'h5});
            wr(8'h02, {3'b111, k[1:0], 3'b111});
            nr = 0;
            ni = 0;
            while ((refp || incp) && ni < 9000) begin
                nr += refp;
                ni += incp;
                cyc(1);
            end
            chk(near(nr, rt[k]), 1'b1);
            chk(near(ni, it[k]), 1'b1);
            chk({awake, rail, baddr}, 16'h01CC);
            rd(8'h02, {3'b111, k[1:0], 3'b101});
            rd(8'h05, {2'b00, k[1:0], 4'h5});
            wr(8'h02, 8'h00);
        end
        $display("test precharge done");
        wr(8'h05, 8'h0E);
        wr(8'h02, 8'h85);
        wr(8'h01, 8'h01);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h00);
        rd(8'h05, 8'h05);
        chk({awake, rail, baddr}, 16'h0002);
        $display("test soft reset done");
        for (int c = 0; c < 16; c++) begin
            wr(8'h05, {4'h0, c[3:0]});
            pin_n = 1'b0;
            nr = 0;
            while (core === 1'b1 && nr < 3000) begin
                cyc(1);
                nr++;
                clean = c[3:2] == 2'h2 && nr >= 20;
            end
            if (c[3:2] == 2'h1) begin
                chk(near(nr, ht[c % 4]), 1'b1);
            end else begin
                chk(16'(nr), (c[3:2] == 2'h2) ? 16'd21 : 16'd1);
            end
            pin_n = 1'b1;
            clean = 1'b0;
            cyc(2);
            chk(core, 1'b1);
        end
        $display("test shutdown done");
        // mid-run hardware reset with new strap levels
        wr(8'h00, 8'h07);
        chk(page, 8'h07);
        rst_n = 1'b0;
        strap = 2'h1;
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
        chk(page, 8'h00);
        chk({core, awake, baddr}, 16'h0101);
        rd(8'h05, 8'h05);
        $display("test hardware reset done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
